// *** logic/pld_lock_top.sv ***
// Purpose: Lock detect and subsystem enable register bank of a synthesizer
// Assumes: Register writes and reads arrive decoded from the serial port
// Notes: Edge inputs are one-cycle pulses synchronous to clk_sys
//
// Overview of operation
// - Lock declared after 5/32/96/256/512/2048/8192/65535 consecutive in-window edges.
// - Config bit 3 enables lock detection; it resets enabled.
// - Bit 6 picks digital timer window (1) or 10 ns analog window (0).
// - Bits 9:7 set digital window: half, 1, 2, 4, ... 64 timer cycles.
// - Bits 11:10 set timer rate, 00 fastest, 11 slowest.
// - Bit 12 keeps timer clock running; cleared means one-shot.
// - With bit 13 set, only the first lock failure triggers a relock attempt; a config write rearms it.
// - Pad enable 0 disables pad; else always on or released on foreign address.
// - Enable bits 0..4: bias, pump, phase compare, reference buffer, RF buffer.
// - Bit 7 divider clock to logic, bit 9 prescaler clock, bit 10 prescaler bias.
`timescale 1ns/1ps
`include "pld_cfg.svh"
module pld_lock_top
  import pld_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic wr_en, // Register write strobe
  input wire logic [`PLD_ADDR_W-1:0] wr_addr, // Register write address
  input wire logic [`PLD_DATA_W-1:0] wr_data, // Register write data
  input wire logic rd_en, // Register read strobe
  input wire logic [`PLD_ADDR_W-1:0] rd_addr, // Register read address
  output logic [`PLD_DATA_W-1:0] rd_data, // Read data, one cycle after rd_en
  input wire logic ref_edge, // Reference edge, opens the window
  input wire logic div_edge, // Divided oscillator edge
  input wire logic pad_always_on, // Companion pad control bit
  input wire logic addr_mismatch, // Foreign chip address seen on serial bus
  input wire logic serial_active, // Serial read data owns the pad
  input wire logic serial_data, // Serial read data
  output logic lock_detected, // Lock indication
  output logic relock_req, // One-cycle relock request
  output logic lock_or_serial_out_pin, // Pad output value
  output logic lock_or_serial_out_pin_oe, // Pad output enable
  output logic bias_on, // Main bias reference enable
  output logic pump_on, // Charge pump enable
  output logic phase_compare_on, // Phase detector enable
  output logic ref_buf_on, // Reference path buffer enable
  output logic osc_buf_on, // Oscillator RF buffer enable
  output logic divider_clock_to_logic_on, // Divider clock to logic enable
  output logic presc_clk_on, // Prescaler clock enable
  output logic presc_bias_on // Oscillator buffer and prescaler bias enable
);
  pld_word_t cfg_q, cfg_d, en_q, en_d, rd_q, rd_d;
  pld_st_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic lock_q, lock_d, relock_q, relock_d, tried_q, tried_d;
  logic oe_q, oe_d, pin_q, pin_d;
  logic [3:0] ana_q, ana_d;
  logic cfg_wr, en_wr, in_win, ld_on, fail;
  logic [CNT_W:0] target;

  pld_win_if win ();

  generate
    if (CNT_W < 16) begin : g_chk
      $error("CNT_W must hold the largest lock count");
    end
  endgenerate

  function automatic logic [CNT_W:0] lock_target(input logic [2:0] sel);
    case (sel)
      3'h0: lock_target = (CNT_W+1)'(5);
      3'h1: lock_target = (CNT_W+1)'(32);
      3'h2: lock_target = (CNT_W+1)'(96);
      3'h3: lock_target = (CNT_W+1)'(256);
      3'h4: lock_target = (CNT_W+1)'(512);
      3'h5: lock_target = (CNT_W+1)'(2048);
      3'h6: lock_target = (CNT_W+1)'(8192);
      default: lock_target = (CNT_W+1)'(65535);
    endcase
  endfunction

  // ==================================================
  // Registers
  always_comb begin
    cfg_wr = wr_en && wr_addr == `PLD_LD_CFG_ADDR;
    en_wr = wr_en && wr_addr == `PLD_EN_ADDR;
    cfg_d = cfg_wr ? (wr_data & `PLD_LD_CFG_MASK) : cfg_q;
    en_d = en_wr ? wr_data : en_q;
    rd_d = rd_q;
    if (rd_en) begin
      case (rd_addr)
        `PLD_LD_CFG_ADDR: rd_d = cfg_q;
        `PLD_EN_ADDR: rd_d = en_q;
        default: rd_d = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cfg_q <= `PLD_LD_CFG_RST;
      en_q <= `PLD_EN_RST;
      rd_q <= 24'h000000;
    end else begin
      cfg_q <= cfg_d;
      en_q <= en_d;
      rd_q <= rd_d;
    end
  end

  // ==================================================
  // Window sources
  assign win.start = ref_edge;
  assign win.freq = cfg_q[`PLD_LD_FREQ_LSB +: 2];
  assign win.dur = cfg_q[`PLD_LD_DUR_LSB +: 3];
  assign win.test = cfg_q[`PLD_LD_TEST_BIT];

  pld_win_timer #(.PRE_W(3)) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .win(win.tmr)
  );

  // Analog one-shot stand-in: fixed window after each reference edge
  always_comb begin
    ana_d = ana_q;
    if (ref_edge) begin
      ana_d = 4'(`PLD_ANA_WIN_CYC > 0 ? `PLD_ANA_WIN_CYC : 1);
    end else if (ana_q != 4'h0) begin
      ana_d = ana_q - 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ana_q <= 4'h0;
    end else begin
      ana_q <= ana_d;
    end
  end

  // ==================================================
  // Lock detector
  always_comb begin
    ld_on = cfg_q[`PLD_LD_ENABLE_BIT];
    in_win = cfg_q[`PLD_LD_WTYPE_BIT] ? win.open : (ana_q != 4'h0);
    target = lock_target(cfg_q[`PLD_LD_CNT_LSB +: 3]);
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      PLD_IDLE: begin
        cnt_d = '0;
        if (ld_on) begin
          st_d = PLD_HUNT;
        end
      end
      PLD_HUNT, PLD_LOCKED: begin
        if (div_edge && in_win) begin
          cnt_d = (&cnt_q) ? cnt_q : cnt_q + CNT_W'(1);
          if ({1'b0, cnt_q} + (CNT_W+1)'(1) >= target) begin
            st_d = PLD_LOCKED;
          end
        end else if (div_edge) begin
          cnt_d = '0;
          st_d = PLD_HUNT;
        end
      end
      default: st_d = PLD_IDLE;
    endcase
    if (!ld_on) begin
      st_d = PLD_IDLE;
      cnt_d = '0;
    end
    lock_d = st_d == PLD_LOCKED;
    fail = lock_q && !lock_d;
    relock_d = fail && cfg_q[`PLD_LD_RELOCK_BIT] && !tried_q;
    tried_d = relock_d || (tried_q && !cfg_wr);
    oe_d = en_q[`PLD_EN_PAD_BIT] && (pad_always_on || !addr_mismatch);
    pin_d = serial_active ? serial_data : lock_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_q <= PLD_IDLE;
      cnt_q <= '0;
      lock_q <= 1'b0;
      relock_q <= 1'b0;
      tried_q <= 1'b0;
      oe_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lock_q <= lock_d;
      relock_q <= relock_d;
      tried_q <= tried_d;
      oe_q <= oe_d;
      pin_q <= pin_d;
    end
  end

  // ==================================================
  // Outputs
  assign rd_data = rd_q;
  assign lock_detected = lock_q;
  assign relock_req = relock_q;
  assign lock_or_serial_out_pin = pin_q;
  assign lock_or_serial_out_pin_oe = oe_q;
  assign bias_on = en_q[`PLD_EN_BIAS_BIT];
  assign pump_on = en_q[`PLD_EN_PUMP_BIT];
  assign phase_compare_on = en_q[`PLD_EN_PHASE_BIT];
  assign ref_buf_on = en_q[`PLD_EN_REFBUF_BIT];
  assign osc_buf_on = en_q[`PLD_EN_OSCBUF_BIT];
  assign divider_clock_to_logic_on = en_q[`PLD_EN_DIVCLK_BIT];
  assign presc_clk_on = en_q[`PLD_EN_PRESC_BIT];
  assign presc_bias_on = en_q[`PLD_EN_PBIAS_BIT];

  // ==================================================
  // Checks
  a_lock_needs_count: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(lock_q) |-> ({1'b0, cnt_q} >= target))
    else $error("Lock declared before enough consecutive edges");
  a_disabled_no_lock: assert property (@(posedge clk_sys) disable iff (!resetn)
    !cfg_q[`PLD_LD_ENABLE_BIT] |=> !lock_q && cnt_q == '0)
    else $error("Lock detector active while disabled");
  a_analog_win_miss: assert property (@(posedge clk_sys) disable iff (!resetn)
    (ld_on && !cfg_q[`PLD_LD_WTYPE_BIT] && ana_q == 4'h0 && div_edge && st_q != PLD_IDLE)
    |=> cnt_q == '0)
    else $error("Edge outside analog window was counted");
  a_relock_once: assert property (@(posedge clk_sys) disable iff (!resetn)
    (tried_q && !cfg_wr) |=> !relock_q)
    else $error("Second relock attempt issued");
  a_relock_on_fail: assert property (@(posedge clk_sys) disable iff (!resetn)
    (fail && cfg_q[`PLD_LD_RELOCK_BIT] && !tried_q) |=> relock_q ##1 !relock_q)
    else $error("Lock failure did not give one relock pulse");
  a_pad_disable: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!en_q[`PLD_EN_PAD_BIT] || (!pad_always_on && addr_mismatch)) |=> !oe_q)
    else $error("Pad driven while disabled or released");
  a_enable_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    en_wr |=> {osc_buf_on, ref_buf_on, phase_compare_on, pump_on, bias_on}
      == $past(wr_data[4:0]))
    else $error("Enable outputs do not follow the written value");
  a_clock_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    en_wr |=> {presc_bias_on, presc_clk_on, divider_clock_to_logic_on}
      == {$past(wr_data[10]), $past(wr_data[9]), $past(wr_data[7])})
    else $error("Clock enables do not follow the written value");
  a_miss_drops_lock: assert property (@(posedge clk_sys) disable iff (!resetn)
    (lock_q && div_edge && !in_win) |=> !lock_q && cnt_q == '0)
    else $error("Out-of-window edge kept lock or count");
  c_lock_seen: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(lock_q));
  c_relock_seen: cover property (@(posedge clk_sys) disable iff (!resetn) relock_q);
  c_pad_release: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(oe_q));
endmodule

// *** inc/pld_cfg.svh ***
// Purpose: Constants of the lock detect and subsystem enable register bank
// Assumes: 100 MHz system clock
// Notes: Offsets are register addresses on the serial register port
`ifndef PLD_CFG_SVH
`define PLD_CFG_SVH
// ==================================================
// Register map
`define PLD_ADDR_W 5
`define PLD_DATA_W 24
`define PLD_LD_CFG_ADDR 5'h07
`define PLD_EN_ADDR 5'h08
`define PLD_LD_CFG_RST 24'h00014d
`define PLD_EN_RST 24'hc1beff
`define PLD_LD_CFG_MASK 24'h003fff
// ==================================================
// Lock detect config fields
`define PLD_LD_CNT_LSB 0
`define PLD_LD_ENABLE_BIT 3
`define PLD_LD_WTYPE_BIT 6
`define PLD_LD_DUR_LSB 7
`define PLD_LD_FREQ_LSB 10
`define PLD_LD_TEST_BIT 12
`define PLD_LD_RELOCK_BIT 13
// ==================================================
// Enable register fields
`define PLD_EN_BIAS_BIT 0
`define PLD_EN_PUMP_BIT 1
`define PLD_EN_PHASE_BIT 2
`define PLD_EN_REFBUF_BIT 3
`define PLD_EN_OSCBUF_BIT 4
`define PLD_EN_PAD_BIT 5
`define PLD_EN_DIVCLK_BIT 7
`define PLD_EN_PRESC_BIT 9
`define PLD_EN_PBIAS_BIT 10
// ==================================================
// Timing
`define PLD_CLK_PERIOD_PS 10000
`define PLD_ANA_WIN_NS 10
`define PLD_ANA_WIN_CYC ((`PLD_ANA_WIN_NS * 1000) / `PLD_CLK_PERIOD_PS)
`endif

// *** inc/pld_pkg.sv ***
// Purpose: Types of the lock detect register bank
// Assumes: Nothing
// Notes: Constants live in pld_cfg.svh
package pld_pkg;
  typedef enum logic [1:0] {PLD_IDLE, PLD_HUNT, PLD_LOCKED} pld_st_e;
  typedef logic [23:0] pld_word_t;
endpackage

// *** inc/pld_win_if.sv ***
// Purpose: Carrier between lock detector and digital window timer
// Assumes: One clock domain
// Notes: ctl side starts the window, tmr side reports it open
`timescale 1ns/1ps
interface pld_win_if;
  logic start;
  logic [1:0] freq;
  logic [2:0] dur;
  logic test;
  logic open;
  modport ctl (output start, output freq, output dur, output test, input open);
  modport tmr (input start, input freq, input dur, input test, output open);
endinterface

// *** logic/pld_win_timer.sv ***
// Purpose: Digital programmable lock detect window
// Assumes: start is a one-cycle pulse on the reference edge
// Notes: Window length in half timer cycles is 1 << dur; timer cycle is 2 << freq clocks
`timescale 1ns/1ps
module pld_win_timer
  import pld_pkg::*;
#(
  parameter int PRE_W = 3
) (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Synchronous reset, active low
  pld_win_if.tmr win // Window control and status
);
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [7:0] halves_q, halves_d;
  logic open_q, open_d;
  logic tick;

  generate
    if (PRE_W < 3) begin : g_chk
      $error("PRE_W too small for slowest timer rate");
    end
  endgenerate

  // ==================================================
  // Timer
  always_comb begin
    tick = (win.test || open_q) && (pre_q == PRE_W'((1 << win.freq) - 1));
    pre_d = pre_q;
    halves_d = halves_q;
    open_d = open_q;
    if (win.start && !open_q) begin
      open_d = 1'b1;
      halves_d = 8'h01 << win.dur;
      pre_d = '0;
    end else begin
      if (win.test || open_q) begin
        pre_d = tick ? '0 : pre_q + PRE_W'(1);
      end else begin
        pre_d = '0;
      end
      if (open_q && tick) begin
        halves_d = halves_q - 8'h01;
        if (halves_q == 8'h01) begin
          open_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pre_q <= '0;
      halves_q <= 8'h00;
      open_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      halves_q <= halves_d;
      open_q <= open_d;
    end
  end

  assign win.open = open_q;

  // ==================================================
  // Checks
  a_two_half_win: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($rose(open_q) && win.dur == 3'h1 && win.freq == 2'h0)
    |-> open_q [*2] ##1 !open_q)
    else $error("Window of one cycle at fastest rate has wrong length");
  a_slow_half_win: assert property (@(posedge clk_sys) disable iff (!resetn)
    ($rose(open_q) && win.dur == 3'h0 && win.freq == 2'h2 && $stable(win.freq))
    |-> open_q [*4] ##1 !open_q)
    else $error("Half-cycle window at rate two has wrong length");
  a_oneshot_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!win.test && !open_q && !win.start) |=> pre_q == '0)
    else $error("Timer clock runs while idle outside test mode");
  c_win_open: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(open_q));
endmodule

// *** sim/pld_host.sv ***
// Purpose: Host controller model writing and reading the register port
// Assumes: Tasks are entered at a falling edge of clk_sys
// Notes: Host-owned fixed bits are applied to every enable write
`timescale 1ns/1ps
`include "pld_cfg.svh"
module pld_host
  import pld_pkg::*;
#(
  parameter int XTAL_MHZ = 100
) (
  input wire logic clk_sys, // System clock
  output logic wr_en, // Write strobe
  output logic [`PLD_ADDR_W-1:0] wr_addr, // Write address
  output logic [`PLD_DATA_W-1:0] wr_data, // Write data
  output logic rd_en, // Read strobe
  output logic [`PLD_ADDR_W-1:0] rd_addr, // Read address
  input wire logic [`PLD_DATA_W-1:0] rd_data // Read data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_addr = 5'h00;
    rd_addr = 5'h00;
    wr_data = 24'h000000;
  end
  // Idle bus shows inverted values, never the last one
  task automatic wr(input logic [4:0] a, input pld_word_t d);
    pld_word_t v;
    v = d;
    if (a == `PLD_EN_ADDR) begin
      v[11] = 1'b1;
      v[20] = 1'b0;
      v[23:22] = 2'h3;
      v[21] = (XTAL_MHZ > 200);
    end
    wr_en = 1'b1;
    wr_addr = a;
    wr_data = v;
    @(negedge clk_sys);
    wr_en = 1'b0;
    wr_addr = ~a;
    wr_data = ~v;
    // Idle edge so a following transfer never re-raises a strobe in this time step
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [4:0] a, output pld_word_t d);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk_sys);
    rd_en = 1'b0;
    rd_addr = ~a;
    d = rd_data;
    @(negedge clk_sys);
  endtask
endmodule

// *** sim/tb.sv ***
// Purpose: Self-checking bench of the lock detect register bank
// Assumes: Inputs change at the falling edge of clk_sys
// Notes: Edges are one-cycle pulses; the partner host owns the register port
`timescale 1ns/1ps
`include "pld_cfg.svh"
module tb
  import pld_pkg::*;
;
  logic clk_sys, resetn, wr_en, rd_en, ref_edge, div_edge;
  logic pad_always_on, addr_mismatch, serial_active, serial_data;
  logic [4:0] wr_addr, rd_addr;
  pld_word_t wr_data, rd_data, v;
  logic lock_detected, relock_req, pin, pin_oe;
  logic [7:0] en_o;
  int num_errors = 0;
  int compares = 0;
  int n_relock = 0;
  int n0;
  logic [2:0] pad_tab [3] = '{3'b010, 3'b001, 3'b111};
  pld_lock_top dut (.clk_sys(clk_sys), .resetn(resetn), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .ref_edge(ref_edge), .div_edge(div_edge), .pad_always_on(pad_always_on),
    .addr_mismatch(addr_mismatch), .serial_active(serial_active), .serial_data(serial_data),
    .lock_detected(lock_detected), .relock_req(relock_req), .lock_or_serial_out_pin(pin),
    .lock_or_serial_out_pin_oe(pin_oe), .bias_on(en_o[0]), .pump_on(en_o[1]),
    .phase_compare_on(en_o[2]), .ref_buf_on(en_o[3]), .osc_buf_on(en_o[4]),
    .divider_clock_to_logic_on(en_o[5]), .presc_clk_on(en_o[6]), .presc_bias_on(en_o[7]));
  pld_host host (.clk_sys(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));
  // ==================================================
  // Clock, watchdog and relock pulse counter
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  // Sampled mid-cycle, where the registered pulse is settled
  always @(negedge clk_sys) begin
    if (relock_req === 1'b1) n_relock <= n_relock + 1;
  end
  // ==================================================
  // Shared tasks
  task automatic chk(input string what, input pld_word_t exp, input pld_word_t got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic lone();
    div_edge = 1'b1;
    @(negedge clk_sys);
    div_edge = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  // Divided edge lands gap cycles after the reference edge
  task automatic pair(input int gap);
    ref_edge = 1'b1;
    @(negedge clk_sys);
    ref_edge = 1'b0;
    repeat (gap - 1) @(negedge clk_sys);
    div_edge = 1'b1;
    @(negedge clk_sys);
    div_edge = 1'b0;
    repeat (12) @(negedge clk_sys);
  endtask
  task automatic run(input pld_word_t cfg, input int gap, input int n, input logic exp);
    lone();
    host.wr(`PLD_LD_CFG_ADDR, cfg);
    repeat (n - 1) pair(gap);
    chk("lock early", 24'h0, 24'(lock_detected));
    pair(gap);
    chk("lock", 24'(exp), 24'(lock_detected));
    chk("pad lock", 24'(exp), 24'(pin));
  endtask
  // ==================================================
  // Scenarios
  task automatic t_regs();
    chk("enables at reset", 24'hff, 24'(en_o));
    host.rd(`PLD_LD_CFG_ADDR, v);
    chk("config reset", `PLD_LD_CFG_RST, v);
    host.rd(`PLD_EN_ADDR, v);
    chk("enable reset", `PLD_EN_RST, v);
    host.wr(5'h1f, 24'h123456);
    host.rd(5'h1f, v);
    chk("unmapped", 24'h0, v);
    host.rd(`PLD_EN_ADDR, v);
    chk("enable kept", `PLD_EN_RST, v);
    host.wr(`PLD_LD_CFG_ADDR, 24'hffffff);
    host.rd(`PLD_LD_CFG_ADDR, v);
    chk("config mask", `PLD_LD_CFG_MASK, v);
  endtask
  task automatic t_enables();
    host.wr(`PLD_EN_ADDR, 24'h000295);
    @(negedge clk_sys);
    chk("enable outs a", 24'h75, 24'(en_o));
    host.rd(`PLD_EN_ADDR, v);
    chk("enable read a", 24'hc00a95, v);
    host.wr(`PLD_EN_ADDR, 24'h00056a);
    @(negedge clk_sys);
    chk("enable outs b", 24'h8a, 24'(en_o));
    host.rd(`PLD_EN_ADDR, v);
    chk("enable read b", 24'hc00d6a, v);
  endtask
  task automatic t_pad();
    for (int i = 0; i < 3; i++) begin
      {pad_always_on, addr_mismatch} = pad_tab[i][2:1];
      repeat (3) @(negedge clk_sys);
      chk("pad oe", 24'(pad_tab[i][0]), 24'(pin_oe));
    end
    serial_active = 1'b1;
    serial_data = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk("pad serial 1", 24'h1, 24'(pin));
    serial_data = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("pad serial 0", 24'h0, 24'(pin));
    serial_active = 1'b0;
    host.wr(`PLD_EN_ADDR, 24'h000295);
    repeat (2) @(negedge clk_sys);
    chk("pad off", 24'h0, 24'(pin_oe));
  endtask
  task automatic t_relock();
    run(24'h002008, 1, 5, 1'b1);
    n0 = n_relock;
    lone();
    chk("lock drop", 24'h0, 24'(lock_detected));
    chk("relock first", 24'(n0 + 1), 24'(n_relock));
    repeat (5) pair(1);
    lone();
    chk("relock once", 24'(n0 + 1), 24'(n_relock));
  endtask
  // ==================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    ref_edge = 1'b0;
    div_edge = 1'b0;
    pad_always_on = 1'b0;
    addr_mismatch = 1'b0;
    serial_active = 1'b0;
    serial_data = 1'b0;
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    @(negedge clk_sys);
    t_regs();
    t_enables();
    t_pad();
    run(24'h000008, 1, 5, 1'b1);
    run(24'h000009, 1, 32, 1'b1);
    run(24'h000000, 1, 5, 1'b0);
    run(24'h000148, 3, 5, 1'b1);
    run(24'h000048, 3, 5, 1'b0);
    run(24'h000548, 6, 5, 1'b1);
    run(24'h000148, 6, 5, 1'b0);
    run(24'h0000c8, 2, 5, 1'b1);
    run(24'h000848, 3, 5, 1'b1);
    run(24'h001148, 3, 5, 1'b1);
    t_relock();
    finish_test();
  end
endmodule
